// ### sep_memory.sv
/*
  Memory end of the serial command port: frame decoder, array and
  self-timed program timer.
  Assumes the pins are asynchronous to mclk and are synchronised here.
*/
`default_nettype none

// Notes on behaviour
// - Select high selects; low means standby.
// - Started program cycle finishes despite select falling.
// - Select low resets command decoding logic.
// - Master keeps select low minimum deselect time.
// - Input bits sampled on rising serial clock.
// - Read data advances each rising serial clock.
// - Stopped clock leaves sequence state unchanged.
// - Clock ignored while select is low.
// - Without start bit, clock edges change nothing.
// - Program cycle runs on internal timer.
// - Too few edges and nothing executes; edges beyond the full count are ignored.
// - After full count, inputs ignored until reselect.
// - Byte write 1 ms; bulk cycles 15 ms.
// - Array is 128x8 or 64x16 by organization.
// - Single write erases location before programming.
// - Status output shows write in progress.
// - Start bit is first edge with input high.
// - Opcodes decode; then six or seven address bits.
// - Read gives dummy zero then word MSB first.
// - Starts write-disabled; enable command unlocks writes.

module sep_memory #(
  parameter int BYTE_CYC = sep_pkg::BYTE_PROG_CYC,
  parameter int WORD_CYC = sep_pkg::WORD_PROG_CYC,
  parameter int BULK_CYC = sep_pkg::BULK_PROG_CYC
) (
  // System.
  input wire logic mclk,
  input wire logic rst,
  // Link.
  sep_if.memory link
);
  import sep_pkg::*;

  initial
  begin
    if (BYTE_CYC < 1 || WORD_CYC < 1 || BULK_CYC < BYTE_CYC ||
        BULK_CYC >= 2 ** 24 || WORD_CYC >= 2 ** 24)
      $error("sep_memory: bad program cycle counts");
  end

  typedef enum logic [4:0] {
    IDLE = 5'b00001,
    SHIFT = 5'b00010,
    READOUT = 5'b00100,
    DONE = 5'b01000,
    PROG = 5'b10000
  } sep_state_t;

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  logic [1:0] selSync, clkSync, inSync, orgSync;
  logic clkPrev;
  logic sel, risingEdge, wide;

  always_ff @(posedge mclk)
  begin
    selSync <= {selSync[0], link.select};
    clkSync <= {clkSync[0], link.serialClk};
    inSync <= {inSync[0], link.serialIn};
    orgSync <= {orgSync[0], link.organizationSelect};
    clkPrev <= clkSync[1];
  end

  always_comb
  begin
    sel = selSync[1];
    wide = orgSync[1];
    risingEdge = clkSync[1] & ~clkPrev;
  end

  // ----------------------------------------------------------------------
  // Array and decoder.
  // ----------------------------------------------------------------------
  logic [7:0] mem [ARRAY_BYTES];
  sep_state_t state, next_state;
  logic [4:0] edgeCnt, next_edgeCnt;
  logic [26:0] shiftReg, next_shiftReg;
  logic [15:0] outWord, next_outWord;
  logic [4:0] outCnt, next_outCnt;
  logic writeEn, next_writeEn;
  logic [23:0] timer, next_timer;
  logic [1:0] progKind, next_progKind;
  logic [6:0] progAddr, next_progAddr;
  logic [15:0] progData, next_progData;
  logic serialOut, next_serialOut;
  logic serialOutEn, next_serialOutEn;
  logic readyBusy, next_readyBusy;
  logic [3:0] opc;
  logic [6:0] addr;
  logic [15:0] wdata;
  logic [4:0] cmdEdges, dataEdges;
  logic [26:0] hold;

  always_comb
  begin
    cmdEdges = wide ? 5'(CMD_EDGES_WIDE) : 5'(CMD_EDGES_NARROW);
    dataEdges = wide ? 5'(DATA_EDGES_WIDE) : 5'(DATA_EDGES_NARROW);
    // Once the data bits are in, opcode and address sit above them.
    hold = shiftReg;
    if (edgeCnt == dataEdges)
      hold = wide ? shiftReg >> DATA_BITS_WIDE : shiftReg >> DATA_BITS_NARROW;
    // Frame bits as held after the edge that completes the address.
    if (wide)
    begin
      opc = hold[9:6];
      addr = {1'b0, hold[5:0]};
      wdata = shiftReg[15:0];
    end
    else
    begin
      opc = hold[10:7];
      addr = hold[6:0];
      wdata = {8'h00, shiftReg[7:0]};
    end
  end

  always_comb
  begin
    next_state = state;
    next_edgeCnt = edgeCnt;
    next_shiftReg = shiftReg;
    next_outWord = outWord;
    next_outCnt = outCnt;
    next_writeEn = writeEn;
    next_timer = timer;
    next_progKind = progKind;
    next_progAddr = progAddr;
    next_progData = progData;
    next_serialOut = serialOut;
    next_serialOutEn = serialOutEn;
    next_readyBusy = readyBusy;
    case (state)
      IDLE:
      begin
        next_serialOutEn = 1'b0;
        if (sel && risingEdge && inSync[1])
        begin
          next_state = SHIFT;
          next_edgeCnt = 5'd1;
          next_shiftReg = '0;
        end
      end
      SHIFT:
      begin
        if (!sel)
          next_state = IDLE;
        else if (risingEdge)
        begin
          next_shiftReg = {shiftReg[25:0], inSync[1]};
          next_edgeCnt = edgeCnt + 5'd1;
        end
        else if (edgeCnt == cmdEdges)
        begin
          // Address complete: decode without waiting for data bits.
          if (opc[3:2] == 2'b10)
          begin
            next_outWord = wide ? mem_word(addr) : {mem[addr], 8'h00};
            next_outCnt = wide ? 5'(DATA_BITS_WIDE) : 5'(DATA_BITS_NARROW);
            next_serialOut = 1'b0;
            next_serialOutEn = 1'b1;
            next_state = READOUT;
          end
          else if (opc == ENABLE_WRITES_CMD)
          begin
            next_writeEn = 1'b1;
            next_state = DONE;
          end
          else if (opc == DISABLE_WRITES_CMD)
          begin
            next_writeEn = 1'b0;
            next_state = DONE;
          end
          else if (opc == ERASE_ALL_CMD)
          begin
            next_state = writeEn ? PROG : DONE;
            next_progKind = 2'd1;
            next_timer = 24'(BULK_CYC);
            next_readyBusy = ~writeEn;
          end
        end
        else if (edgeCnt == dataEdges)
        begin
          next_progAddr = addr;
          next_progData = wdata;
          next_progKind = opc[2] ? 2'd0 : 2'd2;
          next_timer = opc[2] ? (wide ? 24'(WORD_CYC) : 24'(BYTE_CYC))
                              : 24'(BULK_CYC);
          next_state = writeEn ? PROG : DONE;
          next_readyBusy = ~writeEn;
        end
      end
      READOUT:
      begin
        if (!sel)
        begin
          next_serialOutEn = 1'b0;
          next_state = IDLE;
        end
        else if (risingEdge)
        begin
          if (outCnt == 5'd0)
          begin
            next_serialOutEn = 1'b0;
            next_state = DONE;
          end
          else
          begin
            next_serialOut = outWord[15];
            next_outWord = {outWord[14:0], 1'b0};
            next_outCnt = outCnt - 5'd1;
          end
        end
      end
      DONE:
      begin
        next_serialOutEn = 1'b0;
        if (!sel)
          next_state = IDLE;
      end
      PROG:
      begin
        // Runs on mclk alone, whatever select and the serial clock do.
        if (timer <= 24'd1)
        begin
          next_readyBusy = 1'b1;
          next_state = DONE;
        end
        else
          next_timer = timer - 24'd1;
      end
      default:
        next_state = IDLE;
    endcase
  end

  function automatic logic [15:0] mem_word(input logic [6:0] a);
    mem_word = {mem[{a[5:0], 1'b0}], mem[{a[5:0], 1'b1}]};
  endfunction : mem_word

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= IDLE;
      edgeCnt <= '0;
      shiftReg <= '0;
      outWord <= '0;
      outCnt <= '0;
      writeEn <= 1'b0;
      timer <= '0;
      progKind <= '0;
      progAddr <= '0;
      progData <= '0;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
      readyBusy <= 1'b1;
    end
    else
    begin
      state <= next_state;
      edgeCnt <= next_edgeCnt;
      shiftReg <= next_shiftReg;
      outWord <= next_outWord;
      outCnt <= next_outCnt;
      writeEn <= next_writeEn;
      timer <= next_timer;
      progKind <= next_progKind;
      progAddr <= next_progAddr;
      progData <= next_progData;
      serialOut <= next_serialOut;
      serialOutEn <= next_serialOutEn;
      readyBusy <= next_readyBusy;
    end
  end

  // ----------------------------------------------------------------------
  // Array update at the end of a program cycle.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (state == PROG && timer <= 24'd1)
    begin
      for (int i = 0; i < ARRAY_BYTES; i++)
      begin
        if (progKind == 2'd1)
          mem[i] <= 8'hff;
        else if (progKind == 2'd2)
          mem[i] <= (wide && i[0] == 1'b0) ? progData[15:8] : progData[7:0];
      end
      // Erase then program collapses into one overwrite.
      if (progKind == 2'd0 && wide)
      begin
        mem[{progAddr[5:0], 1'b0}] <= progData[15:8];
        mem[{progAddr[5:0], 1'b1}] <= progData[7:0];
      end
      else if (progKind == 2'd0)
        mem[progAddr] <= progData[7:0];
    end
  end

  assign link.serialOut = serialOut;
  assign link.serialOutEn = serialOutEn;
  assign link.readyBusyOut = readyBusy;

endmodule : sep_memory

`default_nettype wire

// ### sep_pkg.sv
/*
  Package for the serial memory command port: opcodes, widths, counts and
  timing constants shared by the memory end and the master end.
  Assumes a 100 MHz system clock on both ends.
*/
`default_nettype none

package sep_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing.
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_DESELECT_TIME_NS = 100;
  localparam int MIN_DESELECT_CYC =
    (MIN_DESELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_PROG_TIME_MS = 1;
  localparam int WORD_PROG_TIME_MS = 2;
  localparam int BULK_PROG_TIME_MS = 15;
  localparam int BYTE_PROG_CYC = BYTE_PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WORD_PROG_CYC = WORD_PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BULK_PROG_CYC = BULK_PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 50;

  // ----------------------------------------------------------------------
  // Frame layout.
  // ----------------------------------------------------------------------
  localparam int OPCODE_BITS = 4;
  localparam int ADDR_BITS_WIDE = 6;
  localparam int ADDR_BITS_NARROW = 7;
  localparam int DATA_BITS_WIDE = 16;
  localparam int DATA_BITS_NARROW = 8;
  localparam int CMD_EDGES_WIDE = 11;
  localparam int CMD_EDGES_NARROW = 12;
  localparam int DATA_EDGES_WIDE = 27;
  localparam int DATA_EDGES_NARROW = 20;
  localparam int ARRAY_BYTES = 128;

  // ----------------------------------------------------------------------
  // Opcodes (four bits after the start bit).
  // ----------------------------------------------------------------------
  localparam logic [3:0] ENABLE_WRITES_CMD = 4'h3;
  localparam logic [3:0] DISABLE_WRITES_CMD = 4'h0;
  localparam logic [3:0] ERASE_ALL_CMD = 4'h2;
  localparam logic [3:0] WRITE_ALL_CMD = 4'h1;
  localparam logic [3:0] READ_CMD = 4'h8;
  localparam logic [3:0] WRITE_CMD = 4'h4;

endpackage : sep_pkg

`default_nettype wire

// ### sep_if.sv
/*
  Serial link between the memory end and the master end.
  Assumes the bench resolves the shared data-out wire from its enable.
*/
`default_nettype none

interface sep_if;
  logic select;
  logic serialClk;
  logic serialIn;
  logic serialOut;
  logic serialOutEn;
  logic organizationSelect;
  logic readyBusyOut;

  modport memory (
    input select,
    input serialClk,
    input serialIn,
    input organizationSelect,
    output serialOut,
    output serialOutEn,
    output readyBusyOut
  );

  modport master (
    output select,
    output serialClk,
    output serialIn,
    input serialOut,
    input serialOutEn,
    input readyBusyOut
  );
endinterface : sep_if

`default_nettype wire

// ### sep_master.sv
/*
  Master end of the serial command port: builds one frame per request.
  Assumes the memory end's outputs are asynchronous and synchronises them.
*/
`default_nettype none

module sep_master (
  // System.
  input wire logic mclk,
  input wire logic rst,
  // Request.
  input wire logic reqValid,
  input wire logic [3:0] reqOpcode,
  input wire logic [6:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic wideOrg,
  // Answer.
  output logic reqReady,
  output logic [15:0] readData,
  output logic readValid,
  output logic memReady,
  // Link.
  sep_if.master link
);
  import sep_pkg::*;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_LOW = 4'b0010,
    M_HIGH = 4'b0100,
    M_GAP = 4'b1000
  } sep_mstate_t;

  // ----------------------------------------------------------------------
  // Frame engine.
  // ----------------------------------------------------------------------
  sep_mstate_t state, next_state;
  logic [1:0] doSync, rbSync;
  logic [27:0] frame, next_frame;
  logic [4:0] left, next_left;
  logic [6:0] tick, next_tick;
  logic [15:0] rxWord, next_rxWord;
  logic isRead, next_isRead;
  logic sel, next_sel, sclk, next_sclk, sin, next_sin;
  logic rdy, next_rdy, rv, next_rv;
  logic [4:0] edges;

  always_ff @(posedge mclk)
  begin
    doSync <= {doSync[0], link.serialOut};
    rbSync <= {rbSync[0], link.readyBusyOut};
  end

  always_comb
  begin
    edges = reqOpcode[2] || reqOpcode == WRITE_ALL_CMD ?
      (wideOrg ? 5'(DATA_EDGES_WIDE) : 5'(DATA_EDGES_NARROW)) :
      (wideOrg ? 5'(CMD_EDGES_WIDE) : 5'(CMD_EDGES_NARROW));
    next_state = state;
    next_frame = frame;
    next_left = left;
    next_tick = tick;
    next_rxWord = rxWord;
    next_isRead = isRead;
    next_sel = sel;
    next_sclk = sclk;
    next_sin = sin;
    next_rdy = 1'b0;
    next_rv = 1'b0;
    case (state)
      M_IDLE:
      begin
        next_rdy = rbSync[1];
        if (reqValid && rdy)
        begin
          // Start bit, opcode, address, data, left-aligned.
          next_frame = wideOrg ?
            {1'b1, reqOpcode, reqAddr[5:0], reqData, 1'b0} :
            {1'b1, reqOpcode, reqAddr, reqData[7:0], 8'h00};
          next_left = edges;
          next_isRead = reqOpcode[3:2] == 2'b10;
          next_sel = 1'b1;
          next_sin = 1'b1;
          next_tick = 7'(SCLK_HALF_CYC);
          next_rdy = 1'b0;
          next_state = M_LOW;
        end
      end
      M_LOW:
        if (tick == 7'd0)
        begin
          next_sclk = 1'b1;
          next_tick = 7'(SCLK_HALF_CYC);
          next_state = M_HIGH;
        end
        else
          next_tick = tick - 7'd1;
      M_HIGH:
        if (tick == 7'd0)
        begin
          next_sclk = 1'b0;
          next_frame = {frame[26:0], 1'b0};
          next_sin = frame[26];
          next_left = left - 5'd1;
          next_rxWord = {rxWord[14:0], doSync[1]};
          next_tick = 7'(SCLK_HALF_CYC);
          if (left == 5'd1)
          begin
            if (isRead)
            begin
              next_isRead = 1'b0;
              next_left = wideOrg ? 5'd16 : 5'd8;
              next_state = M_LOW;
            end
            else
            begin
              next_sel = 1'b0;
              next_rv = 1'b1;
              next_state = M_GAP;
            end
          end
          else
            next_state = M_LOW;
        end
        else
          next_tick = tick - 7'd1;
      M_GAP:
        // Select low well beyond the minimum deselect time.
        if (tick == 7'd0)
          next_state = M_IDLE;
        else
          next_tick = tick - 7'd1;
      default:
        next_state = M_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= M_IDLE;
      frame <= '0;
      left <= '0;
      tick <= '0;
      rxWord <= '0;
      isRead <= 1'b0;
      sel <= 1'b0;
      sclk <= 1'b0;
      sin <= 1'b0;
      rdy <= 1'b0;
      rv <= 1'b0;
    end
    else
    begin
      state <= next_state;
      frame <= next_frame;
      left <= next_left;
      tick <= next_tick;
      rxWord <= next_rxWord;
      isRead <= next_isRead;
      sel <= next_sel;
      sclk <= next_sclk;
      sin <= next_sin;
      rdy <= next_rdy;
      rv <= next_rv;
    end
  end

  always_ff @(posedge mclk)
  begin
    readValid <= rv;
    readData <= rxWord;
    memReady <= rbSync[1];
  end

  assign reqReady = rdy;
  assign link.select = sel;
  assign link.serialClk = sclk;
  assign link.serialIn = sin;

endmodule : sep_master

`default_nettype wire

// ### sep_asserts.sv
/*
  Checker for the link between the master end and the memory end.
  Assumes mclk samples every link signal and rst is synchronous, high.
*/
`default_nettype none

module sep_asserts #(
  parameter int BYTE_CYC = 50,
  parameter int WORD_CYC = 80,
  parameter int BULK_CYC = 200
) (
  // System.
  input wire logic mclk,
  input wire logic rst,
  // Link.
  input wire logic select,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic organizationSelect,
  input wire logic readyBusyOut
);
  // ----------------------------------------------------------------------
  // Helper counters.
  // ----------------------------------------------------------------------
  logic clkQ, next_clkQ, rise;
  logic [7:0] since, next_since;
  logic [5:0] edges, next_edges;
  logic [21:0] busyCnt, next_busyCnt;

  assign rise = serialClk && !clkQ;

  always_comb
  begin
    next_clkQ = serialClk;
    next_since = rise ? 8'h00 : since + {7'h00, since != 8'hff};
    next_edges = !select ? 6'h00 : edges + {5'h00, rise};
    next_busyCnt = readyBusyOut ? 22'h000000 : busyCnt + 22'h000001;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      clkQ <= 1'b0;
      since <= 8'hff;
      edges <= 6'h00;
      busyCnt <= 22'h000000;
    end
    else
    begin
      clkQ <= next_clkQ;
      since <= next_since;
      edges <= next_edges;
      busyCnt <= next_busyCnt;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  AST_BUSY_LEN: assert property ($rose(readyBusyOut) |->
    busyCnt == BULK_CYC ||
    busyCnt == (organizationSelect ? WORD_CYC : BYTE_CYC))
    else $error("busy time wrong");
  AST_DUMMY: assert property ($rose(serialOutEn) |-> !serialOut &&
    edges == (organizationSelect ? 6'h0b : 6'h0c))
    else $error("dummy bit wrong");
  AST_OUT_SEL: assert property ($rose(serialOutEn) |-> select)
    else $error("output while deselected");
  AST_STANDBY: assert property (!select [*6] |-> !serialOutEn)
    else $error("output left on in standby");
  AST_SHIFT: assert property (serialOutEn && $past(serialOutEn) &&
    $changed(serialOut) |-> since <= 8'h08)
    else $error("output moved without clock");
  AST_PAUSE: assert property (since > 8'h08 && select &&
    $past(select) |-> $stable(serialOutEn))
    else $error("enable moved while clock stopped");
  AST_RESET: assert property ($fell(rst) |->
    readyBusyOut && !serialOutEn)
    else $error("reset state wrong");
  AST_BUSY_QUIET: assert property (!readyBusyOut |-> !serialOutEn)
    else $error("output during program");
  AST_BUSY_START: assert property ($fell(readyBusyOut) |->
    since <= 8'h08)
    else $error("program not started by last edge");
endmodule : sep_asserts

`default_nettype wire

// ### tb.sv
/*
  Testbench: master and memory joined on one link, and a second memory
  driven bit by bit from the bench with faulty frames.
  Assumes short program counts of 50, 80 and 200 cycles on the first memory; the second shortens only the byte count to 50.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sep_pkg::*;

  logic mclk, rst, reqValid, wideOrg, reqReady, readValid, memReady;
  logic [3:0] reqOpcode;
  logic [6:0] reqAddr;
  logic [15:0] reqData, readData, junk;
  logic [8:0] capture2;
  int badCount, checks, busySeen, busyMain;

  sep_if link();
  sep_if link2();

  sep_master u_sep_master (.mclk(mclk), .rst(rst), .reqValid(reqValid),
    .reqOpcode(reqOpcode), .reqAddr(reqAddr), .reqData(reqData),
    .wideOrg(wideOrg), .reqReady(reqReady), .readData(readData),
    .readValid(readValid), .memReady(memReady), .link(link.master));
  sep_memory #(.BYTE_CYC(50), .WORD_CYC(80), .BULK_CYC(200)) u_sep_memory
    (.mclk(mclk), .rst(rst), .link(link.memory));
  sep_memory #(.BYTE_CYC(50)) u_sep_memory_2
    (.mclk(mclk), .rst(rst), .link(link2.memory));
  sep_asserts u_sep_asserts
    (.mclk(mclk), .rst(rst), .select(link.select),
    .serialClk(link.serialClk), .serialIn(link.serialIn),
    .serialOut(link.serialOut), .serialOutEn(link.serialOutEn),
    .organizationSelect(link.organizationSelect),
    .readyBusyOut(link.readyBusyOut));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(negedge link2.readyBusyOut)
    busySeen++;

  always @(negedge link.readyBusyOut)
    busyMain++;

  // ----------------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      badCount++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic req(input logic [3:0] op, input logic [6:0] a,
                     input logic [15:0] d, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    #1 reqOpcode = op;
    reqAddr = a;
    reqData = d;
    reqValid = 1'b1;
    do @(negedge mclk); while (reqReady !== 1'b1 && ++n < 10000);
    @(posedge mclk);
    #1 reqValid = 1'b0;
    do @(negedge mclk); while (readValid !== 1'b1 && ++n < 10000);
    if (n >= 10000)
    begin
      badCount++;
      $display("mismatch at %0t: request timed out", $time);
    end
    rd = readData;
  endtask : req

  task automatic rdc(input logic [3:0] op, input logic [6:0] a,
                     input logic [15:0] exp);
    logic [15:0] rd;
    req(op, a, 16'h0000, rd);
    if (!wideOrg)
      rd[15:8] = 8'h00;
    check(rd, exp);
  endtask : rdc

  task automatic setOrg(input logic v);
    repeat (300) @(posedge mclk);
    #1 wideOrg = v;
    link.organizationSelect = v;
  endtask : setOrg

  task automatic frame2(input logic [31:0] bits, input int n);
    @(posedge mclk);
    #1 link2.select = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      link2.serialIn = bits[i];
      #40 capture2 = {capture2[7:0],
                      link2.serialOutEn ? link2.serialOut : 1'b1};
      link2.serialClk = 1'b1;
      if (i == 10)
        #1000;
      #40 link2.serialClk = 1'b0;
    end
    #40 capture2 = {capture2[7:0],
                    link2.serialOutEn ? link2.serialOut : 1'b1};
    link2.select = 1'b0;
    link2.serialIn = 1'b0;
    #200;
  endtask : frame2

  task automatic printVerdict();
    if (badCount == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : printVerdict

  // ----------------------------------------------------------------------
  // Tests.
  // ----------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    reqValid = 1'b0;
    reqOpcode = 4'h0;
    reqAddr = 7'h00;
    reqData = 16'h0000;
    wideOrg = 1'b0;
    link.organizationSelect = 1'b0;
    link2.organizationSelect = 1'b0;
    link2.select = 1'b0;
    link2.serialClk = 1'b0;
    link2.serialIn = 1'b0;
    capture2 = 9'h000;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    req(WRITE_CMD, 7'h7f, 16'h005a, junk);
    check(16'(busyMain), 16'h0000);
    check({15'h0000, memReady}, 16'h0001);
    req(ENABLE_WRITES_CMD, 7'h00, 16'h0000, junk);
    req(ERASE_ALL_CMD, 7'h00, 16'h0000, junk);
    check({15'h0000, memReady}, 16'h0000);
    rdc(READ_CMD, 7'h7f, 16'h00ff);
    req(4'hc, 7'h7f, 16'h00a5, junk);
    rdc(READ_CMD, 7'h7f, 16'h00a5);
    req(DISABLE_WRITES_CMD, 7'h00, 16'h0000, junk);
    req(WRITE_CMD, 7'h7f, 16'h005a, junk);
    rdc(4'hb, 7'h7f, 16'h00a5);
    req(ENABLE_WRITES_CMD, 7'h00, 16'h0000, junk);
    req(ERASE_ALL_CMD, 7'h00, 16'h0000, junk);
    rdc(READ_CMD, 7'h7f, 16'h00ff);
    req(WRITE_ALL_CMD, 7'h00, 16'h003c, junk);
    rdc(READ_CMD, 7'h40, 16'h003c);
    req(WRITE_CMD, 7'h0a, 16'h00be, junk);
    req(WRITE_CMD, 7'h0b, 16'h00ef, junk);
    setOrg(1'b1);
    rdc(READ_CMD, 7'h05, 16'hbeef);
    req(WRITE_CMD, 7'h00, 16'h1234, junk);
    setOrg(1'b0);
    rdc(READ_CMD, 7'h00, 16'h0012);
    rdc(READ_CMD, 7'h01, 16'h0034);
    frame2({3'b000, 1'b1, ENABLE_WRITES_CMD, 7'h00}, 15);
    frame2({1'b1, WRITE_CMD, 7'h11, 8'h5a} >> 1, 19);
    repeat (100) @(posedge mclk);
    check(16'(busySeen), 16'h0000);
    frame2({1'b1, WRITE_CMD, 7'h11, 8'h96, 2'b11}, 22);
    repeat (100) @(posedge mclk);
    frame2({1'b1, READ_CMD, 7'h11, 8'h00}, 20);
    check({7'h00, capture2}, {7'h00, 1'b0, 8'h96});
    check(16'(busySeen), 16'h0001);
    check({15'h0000, link2.serialOutEn}, 16'h0000);
    printVerdict();
  end

  initial
  begin
    #1000000;
    badCount++;
    printVerdict();
  end
endmodule : tb

`default_nettype wire
